// ### shared/css_pkg.sv
/*
 * Package for the configuration start-up sequencer: phase states,
 * start-up option record, timing constants and counts in clock cycles.
 * Assumes a 20 MHz system clock.
 */
`default_nettype none
package css_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_NS = 50;

    // power-on reset finish, longest time in microseconds
    localparam int unsigned POR_MAX_US = 2000;
    localparam int unsigned POR_CYCLES = (POR_MAX_US * (CLK_HZ / 1_000_000));
    // restart pulse, least width in ns (rounded up)
    localparam int unsigned RESTART_MIN_NS = 300;
    localparam int unsigned RESTART_CYCLES = (RESTART_MIN_NS + CLK_NS - 1) / CLK_NS;
    // restart latency, longest time in microseconds
    localparam int unsigned RESTART_LAT_US = 100;
    localparam int unsigned RESTART_LAT_CYCLES = RESTART_LAT_US * (CLK_HZ / 1_000_000);
    // config clock output start delay, least and longest in ns
    localparam int unsigned CFG_CLK_DLY_MIN_NS = 500;
    localparam int unsigned CFG_CLK_DLY_MAX_NS = 4000;
    localparam int unsigned CFG_CLK_DLY_CYCLES = (CFG_CLK_DLY_MIN_NS + CLK_NS - 1) / CLK_NS;
    // clearing pass length in cycles
    localparam int unsigned CLEAR_CYCLES = 64;
    // config clock divider half period in system cycles
    localparam int unsigned CFG_CLK_HALF = 2;
    localparam int unsigned NUM_DLL = 8;

    // default start-up positions, in config clock cycles after completion
    localparam logic [2:0] TRISTATE_STEP_RST = 3'h1;
    localparam logic [2:0] SET_RESET_STEP_RST = 3'h2;
    localparam logic [2:0] WRITE_EN_STEP_RST = 3'h2;

    typedef enum logic [2:0] {
        CSS_POR = 3'b000,
        CSS_CLEAR = 3'b001,
        CSS_INIT_WAIT = 3'b010,
        CSS_LOAD = 3'b011,
        CSS_STARTUP = 3'b100,
        CSS_RUN = 3'b101
    } css_state_t;

    typedef struct packed {
        logic [2:0] tristate_step;
        logic [2:0] set_reset_step;
        logic [2:0] write_en_step;
        logic sync_done;
        logic lock_wait;
        logic [2:0] lock_step;
        logic [NUM_DLL-1:0] lock_mask;
        logic lock_all;
    } css_startup_cfg_t;

    typedef struct packed {
        logic global_output_tristate;
        logic global_set_reset;
        logic global_write_enable;
    } css_globals_t;
endpackage : css_pkg
`default_nettype wire

// ### src/css_sequencer.sv
/*
 * Configuration start-up sequencer: clear, load and start-up phases,
 * clear-status and completion pins, global control releases, readback gating.
 * Assumes the data loader reports load done, and pins are open drain outside.
 */
// Summary of operation
// RULE1: configure in order: clear memory, load data, then start-up phase.
// RULE2: begin configuration automatically after power-up.
// RULE3: finish power-on initialization within 2.0 ms before clearing.
// RULE4: restart pulse of 300 ns starts clearing within 100 us.
// RULE5: drive clear-status low while clearing; release it afterwards.
// RULE6: raise completion only after the whole process including start-up; the code releases it on entering CSS_STARTUP.
// RULE7: outside party holds clear-status low only by open drain.
// RULE8: wait while clear-status is held low; no loading until high.
// RULE9: release tristate one config clock after completion by default.
// RULE10: release set/reset and write enable one config clock later.
// RULE11: release positions are configurable.
// RULE12: optionally hold releases until shared completion line is high.
// RULE13: optionally pause start-up at a stage until chosen loops lock.
// RULE14: allow readback of configuration and storage contents.
// RULE15: final clearing pass before clear-status is released.
// RULE16: lock wait keeps completion low until lock; disabled by default.
// RULE17: config clock output starts only after clearing, after a delay.
// RULE18: storage held in initial state until set/reset and write enable released.
`default_nettype none
module css_sequencer
    import css_pkg::*;
#(
    parameter int unsigned POR_CNT = POR_CYCLES,
    parameter int unsigned N_DLL = NUM_DLL
) (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    // restart pin, active low
    input wire logic RESTART_N,
    // clear-status pin, open drain
    input wire logic CLEAR_STATUS_I,
    output logic CLEAR_STATUS_O,
    output logic CLEAR_STATUS_OE,
    // completion pin, open drain with release
    input wire logic DONE_I,
    output logic DONE_O,
    output logic DONE_OE,
    // loader and options
    input wire logic MASTER_MODE,
    input wire logic LOAD_DONE,
    input wire css_startup_cfg_t STARTUP_CFG,
    input wire logic [N_DLL-1:0] DLL_LOCKED,
    // outputs
    output logic CONFIG_CLOCK,
    output logic LOAD_ENABLE,
    output css_globals_t GLOBALS,
    output logic READBACK_ENABLE
);
    logic [1:0] restart_sync_reg;
    logic [1:0] clr_sync_reg;
    logic [1:0] done_sync_reg;
    logic [N_DLL-1:0] lock_s1_reg;
    logic [N_DLL-1:0] lock_s2_reg;
    css_state_t state_reg;
    logic [31:0] cnt_reg;
    logic [3:0] rst_pulse_reg;
    logic restart_req;
    logic [7:0] clr_cnt_reg;
    logic [15:0] cfgclk_dly_reg;
    logic cfgclk_run_reg;
    logic [1:0] div_reg;
    logic cfgclk_reg;
    logic cfgclk_rise;
    logic [2:0] step_reg;
    logic lock_ok;
    logic sync_ok;
    logic stage_hold;
    logic in_startup;

    // pins from outside pass two flops first
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            restart_sync_reg <= 2'h3;
            clr_sync_reg <= 2'h0;
            done_sync_reg <= 2'h0;
            lock_s1_reg <= '0;
            lock_s2_reg <= '0;
        end else if (CE) begin
            restart_sync_reg <= {restart_sync_reg[0], RESTART_N};
            clr_sync_reg <= {clr_sync_reg[0], CLEAR_STATUS_I};
            done_sync_reg <= {done_sync_reg[0], DONE_I};
            lock_s1_reg <= DLL_LOCKED;
            lock_s2_reg <= lock_s1_reg;
        end
    end

    // glitch filter: a low shorter than the least pulse width is ignored
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_pulse_reg <= 4'h0;
        end else if (CE) begin
            if (restart_sync_reg[1]) begin
                rst_pulse_reg <= 4'h0;
            end else if (rst_pulse_reg != 4'(RESTART_CYCLES)) begin
                rst_pulse_reg <= rst_pulse_reg + 4'h1;
            end
        end
    end
    assign restart_req = (rst_pulse_reg == 4'(RESTART_CYCLES - 1)) && !restart_sync_reg[1]; // RULE4

    assign lock_ok = STARTUP_CFG.lock_all ? (&lock_s2_reg)
        : (((lock_s2_reg & STARTUP_CFG.lock_mask[N_DLL-1:0]) == STARTUP_CFG.lock_mask[N_DLL-1:0]));
    assign sync_ok = !STARTUP_CFG.sync_done || done_sync_reg[1]; // RULE12
    assign stage_hold = STARTUP_CFG.lock_wait && (step_reg == STARTUP_CFG.lock_step) && !lock_ok; // RULE13 RULE16
    // releases must never leak out of the earlier phases, whatever step positions are configured
    assign in_startup = (state_reg == CSS_STARTUP) || (state_reg == CSS_RUN); // RULE18

    // phase sequencing
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= CSS_POR;
            cnt_reg <= 32'h0;
            clr_cnt_reg <= 8'h0;
        end else if (CE) begin
            if (restart_req) begin
                state_reg <= CSS_CLEAR; // RULE4
                clr_cnt_reg <= 8'h0;
            end else begin
                case (state_reg)
                    CSS_POR: begin
                        cnt_reg <= cnt_reg + 32'h1;
                        if (cnt_reg >= 32'(POR_CNT - 1)) begin
                            state_reg <= CSS_CLEAR; // RULE2 RULE3
                        end
                    end
                    CSS_CLEAR: begin
                        // count stops at the end of the pass, so a long restart low cannot wrap it
                        if (clr_cnt_reg != 8'(CLEAR_CYCLES - 1)) begin
                            clr_cnt_reg <= clr_cnt_reg + 8'h1;
                        end else if (restart_sync_reg[1]) begin
                            state_reg <= CSS_INIT_WAIT; // RULE15
                        end
                    end
                    CSS_INIT_WAIT: begin
                        if (clr_sync_reg[1]) begin
                            state_reg <= CSS_LOAD; // RULE8
                        end
                    end
                    CSS_LOAD: begin
                        if (LOAD_DONE) begin
                            state_reg <= CSS_STARTUP; // RULE1
                        end
                    end
                    CSS_STARTUP: begin
                        if (step_reg == 3'h7) begin
                            state_reg <= CSS_RUN;
                        end
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    // config clock: divider started a fixed delay after clear-status rises
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cfgclk_dly_reg <= 16'h0;
            cfgclk_run_reg <= 1'b0;
            div_reg <= 2'h0;
            cfgclk_reg <= 1'b0;
        end else if (CE) begin
            if (state_reg == CSS_POR || state_reg == CSS_CLEAR || state_reg == CSS_INIT_WAIT) begin
                cfgclk_dly_reg <= 16'h0;
                cfgclk_run_reg <= 1'b0;
                cfgclk_reg <= 1'b0;
                div_reg <= 2'h0;
            end else if (!cfgclk_run_reg) begin
                cfgclk_dly_reg <= cfgclk_dly_reg + 16'h1;
                cfgclk_run_reg <= (cfgclk_dly_reg == 16'(CFG_CLK_DLY_CYCLES - 1)); // RULE17
            end else if (div_reg == 2'(CFG_CLK_HALF - 1)) begin
                div_reg <= 2'h0;
                cfgclk_reg <= !cfgclk_reg;
            end else begin
                div_reg <= div_reg + 2'h1;
            end
        end
    end
    assign cfgclk_rise = cfgclk_run_reg && !cfgclk_reg && (div_reg == 2'(CFG_CLK_HALF - 1));

    // start-up step counter, one step per config clock
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            step_reg <= 3'h0;
        end else if (CE) begin
            if (!in_startup) begin
                step_reg <= 3'h0;
            end else if (cfgclk_rise && step_reg != 3'h7 && !stage_hold && sync_ok) begin
                step_reg <= step_reg + 3'h1; // RULE13
            end
        end
    end

    // pins and global controls
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CLEAR_STATUS_O <= 1'b0;
            CLEAR_STATUS_OE <= 1'b1;
            DONE_O <= 1'b0;
            DONE_OE <= 1'b1;
            CONFIG_CLOCK <= 1'b0;
            LOAD_ENABLE <= 1'b0;
            GLOBALS <= '{global_output_tristate: 1'b1, global_set_reset: 1'b1, global_write_enable: 1'b0};
            READBACK_ENABLE <= 1'b0;
        end else if (CE) begin
            CLEAR_STATUS_O <= 1'b0;
            CLEAR_STATUS_OE <= (state_reg == CSS_POR) || (state_reg == CSS_CLEAR); // RULE5
            DONE_O <= 1'b0;
            // completion released when the loops are locked, if asked
            DONE_OE <= !((state_reg == CSS_STARTUP || state_reg == CSS_RUN)
                && !(STARTUP_CFG.lock_wait && !lock_ok)); // RULE6 RULE16
            CONFIG_CLOCK <= MASTER_MODE && cfgclk_reg; // RULE17
            LOAD_ENABLE <= (state_reg == CSS_LOAD);
            // releases counted from the completion step, gated by the shared line
            GLOBALS.global_output_tristate <= !(in_startup && sync_ok
                && step_reg >= STARTUP_CFG.tristate_step); // RULE9 RULE11
            GLOBALS.global_set_reset <= !(in_startup && sync_ok
                && step_reg >= STARTUP_CFG.set_reset_step); // RULE10 RULE18
            GLOBALS.global_write_enable <= (in_startup && sync_ok
                && step_reg >= STARTUP_CFG.write_en_step); // RULE10 RULE18
            READBACK_ENABLE <= (state_reg == CSS_RUN); // RULE14
        end
    end

    property p_clear_low;
        @(posedge CLK) disable iff (!NRST)
        (CE && state_reg == CSS_CLEAR) |=> CLEAR_STATUS_OE;
    endproperty
    a_clear_low: assert property (p_clear_low) else $error("clear-status not driven while clearing"); // RULE5

    property p_wait_init;
        @(posedge CLK) disable iff (!NRST)
        (state_reg == CSS_INIT_WAIT && !clr_sync_reg[1] && !restart_req) |=> state_reg == CSS_INIT_WAIT;
    endproperty
    a_wait_init: assert property (p_wait_init) else $error("loading entered while clear-status low"); // RULE8

    property p_done_late;
        @(posedge CLK) disable iff (!NRST)
        !DONE_OE |-> (state_reg == CSS_STARTUP || state_reg == CSS_RUN || $past(state_reg) == CSS_STARTUP
            || $past(state_reg) == CSS_RUN);
    endproperty
    a_done_late: assert property (p_done_late) else $error("completion released before start-up"); // RULE6

    property p_order;
        @(posedge CLK) disable iff (!NRST)
        (state_reg == CSS_LOAD) |-> $past(state_reg) inside {CSS_LOAD, CSS_INIT_WAIT};
    endproperty
    a_order: assert property (p_order) else $error("load phase entered out of order"); // RULE1

    property p_restart;
        @(posedge CLK) disable iff (!NRST)
        (CE && restart_req) |=> state_reg == CSS_CLEAR;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not begin clearing"); // RULE4

    sequence s_write_en_rise;
        !GLOBALS.global_write_enable ##1 GLOBALS.global_write_enable;
    endsequence
    property p_write_en_sync;
        @(posedge CLK) disable iff (!NRST)
        s_write_en_rise |-> $past(sync_ok);
    endproperty
    a_write_en_sync: assert property (p_write_en_sync) else $error("write enable released before shared completion"); // RULE12

    property p_cfg_clk_quiet;
        @(posedge CLK) disable iff (!NRST)
        (state_reg == CSS_CLEAR) |=> ##1 !CONFIG_CLOCK;
    endproperty
    a_cfg_clk_quiet: assert property (p_cfg_clk_quiet) else $error("config clock running during clearing"); // RULE17

    // a restart legally clears the step count even while a stage is held
    property p_lock_hold;
        @(posedge CLK) disable iff (!NRST)
        (CE && stage_hold && !restart_req) |=> $stable(step_reg);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("start-up advanced without lock"); // RULE13
endmodule : css_sequencer
`default_nettype wire

// ### tb/css_partner.sv
/*
 * Board-side model for the sequencer: pull-ups on the clear-status and
 * completion wires, plus external open-drain holds on both.
 * Assumes a device enable that is high means the device pulls the wire low.
 */
`default_nettype none
module css_partner (
    // device pull-down enables
    input wire logic dev_clear_oe,
    input wire logic dev_done_oe,
    // external open-drain holds
    input wire logic hold_clear,
    input wire logic hold_done,
    // resolved wire levels
    output logic clear_wire,
    output logic done_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // the board only ever pulls low, so it can never fight the device
    assign clear_wire = !(dev_clear_oe || hold_clear);
    assign done_wire = !(dev_done_oe || hold_done);
endmodule : css_partner
`default_nettype wire

// ### tb/css_sequencer_tb.sv
/*
 * Self-checking bench for css_sequencer: power-up, restart and start-up runs.
 * Assumes a 20 MHz clock and the board model css_partner for the wires.
 */
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t %s", $time, m); end end
module css_sequencer_tb import css_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR_SIM = 20;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic CE = 1'b1;
    logic RESTART_N = 1'b1;
    logic MASTER_MODE = 1'b1;
    logic LOAD_DONE = 1'b0;
    logic hold_clear = 1'b1;
    logic hold_done = 1'b0;
    logic [NUM_DLL-1:0] locked = '1;
    css_startup_cfg_t cfg = '0;
    wire logic clear_wire;
    wire logic done_wire;
    logic CLEAR_STATUS_O, CLEAR_STATUS_OE, DONE_O, DONE_OE, CONFIG_CLOCK, LOAD_ENABLE, READBACK_ENABLE;
    css_globals_t GLOBALS;
    int n_mismatch = 0;
    int n_compared = 0;
    int pos[3];
    int exp_q[$];
    always #25 CLK = ~CLK;
    css_sequencer #(.POR_CNT(POR_SIM), .N_DLL(NUM_DLL)) css_sequencer_inst (
        .CLK(CLK), .NRST(NRST), .CE(CE), .RESTART_N(RESTART_N),
        .CLEAR_STATUS_I(clear_wire), .CLEAR_STATUS_O(CLEAR_STATUS_O), .CLEAR_STATUS_OE(CLEAR_STATUS_OE),
        .DONE_I(done_wire), .DONE_O(DONE_O), .DONE_OE(DONE_OE), .MASTER_MODE(MASTER_MODE),
        .LOAD_DONE(LOAD_DONE), .STARTUP_CFG(cfg), .DLL_LOCKED(locked), .CONFIG_CLOCK(CONFIG_CLOCK),
        .LOAD_ENABLE(LOAD_ENABLE), .GLOBALS(GLOBALS), .READBACK_ENABLE(READBACK_ENABLE));
    css_partner css_partner_inst (
        .dev_clear_oe(CLEAR_STATUS_OE), .dev_done_oe(DONE_OE), .hold_clear(hold_clear),
        .hold_done(hold_done), .clear_wire(clear_wire), .done_wire(done_wire));
    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask : cyc
    // one whole pass: clearing, external hold, load, start-up releases
    task automatic run_seq(input css_startup_cfg_t c, input int min_t, input int max_t);
        int t;
        int cr;
        int rises;
        logic prev;
        cfg = c;
        hold_clear = 1'b1;
        hold_done = c.sync_done;
        if (c.lock_wait) locked = '0;
        t = 0;
        cr = 0;
        while (CLEAR_STATUS_OE !== 1'b0 && t < 400) begin
            cyc(1);
            t++;
            if (CONFIG_CLOCK === 1'b1) cr++;
        end
        `CHK(cr, 0, "clock out during clearing")
        `CHK(t >= min_t && t <= max_t, 1'b1, "clearing length")
        cyc(50);
        `CHK(LOAD_ENABLE, 1'b0, "load while clear-status held")
        hold_clear = 1'b0;
        t = 0;
        while (LOAD_ENABLE !== 1'b1 && t < 10) begin
            cyc(1);
            t++;
        end
        `CHK(LOAD_ENABLE, 1'b1, "no load phase")
        `CHK(DONE_OE, 1'b1, "completion before start-up")
        LOAD_DONE = 1'b1;
        cyc(1);
        LOAD_DONE = 1'b0;
        if (c.lock_wait) begin
            cyc(100);
            `CHK(DONE_OE, 1'b1, "completion before lock")
            locked = c.lock_mask;
            if (c.lock_all) begin
                cyc(10);
                `CHK(DONE_OE, 1'b1, "one loop taken for all")
                locked = '1;
            end
        end
        t = 0;
        while (DONE_OE !== 1'b0 && t < 50) begin
            cyc(1);
            t++;
        end
        `CHK(DONE_OE, 1'b0, "completion never released")
        `CHK(CLEAR_STATUS_O | DONE_O, 1'b0, "open-drain pin driven high")
        if (c.sync_done) begin
            cyc(100);
            `CHK(GLOBALS.global_output_tristate, 1'b1, "release before shared completion")
            hold_done = 1'b0;
        end
        pos = '{-1, -1, -1};
        rises = 0;
        prev = CONFIG_CLOCK;
        t = 0;
        while (READBACK_ENABLE !== 1'b1 && t < 300) begin
            cyc(1);
            t++;
            if (CONFIG_CLOCK === 1'b1 && prev === 1'b0) rises++;
            prev = CONFIG_CLOCK;
            if (pos[0] < 0 && GLOBALS.global_output_tristate === 1'b0) pos[0] = rises;
            if (pos[1] < 0 && GLOBALS.global_set_reset === 1'b0) pos[1] = rises;
            if (pos[2] < 0 && GLOBALS.global_write_enable === 1'b1) pos[2] = rises;
        end
        `CHK(READBACK_ENABLE, 1'b1, "start-up never ended")
        // gated runs stall the step count, so exact positions are only known ungated
        if (!c.sync_done && !c.lock_wait) begin
            exp_q = {int'(c.tristate_step), int'(c.set_reset_step), int'(c.write_en_step)};
            foreach (pos[i]) `CHK(pos[i], exp_q.pop_front(), "release step")
        end
    endtask : run_seq
    initial begin
        css_startup_cfg_t c;
        int t;
        logic cc;
        c = '0;
        c.tristate_step = TRISTATE_STEP_RST;
        c.set_reset_step = SET_RESET_STEP_RST;
        c.write_en_step = WRITE_EN_STEP_RST;
        cyc(20);
        `CHK(CLEAR_STATUS_OE, 1'b1, "clear-status free in reset")
        `CHK(GLOBALS, 3'h6, "globals not held in reset")
        `CHK(DONE_OE, 1'b1, "completion high in reset")
        void'($urandom(97370));
        NRST = 1'b1;
        run_seq(c, POR_SIM + CLEAR_CYCLES - 2, POR_SIM + CLEAR_CYCLES + 8);
        RESTART_N = 1'b0;
        cyc(3);
        RESTART_N = 1'b1;
        cyc(20);
        `CHK(CLEAR_STATUS_OE, 1'b0, "short restart taken")
        for (int i = 0; i < 5; i++) begin
            c = '0;
            c.tristate_step = 3'($urandom_range(6, 1));
            c.set_reset_step = 3'($urandom_range(6, 1));
            c.write_en_step = 3'($urandom_range(6, 1));
            c.sync_done = (i == 3);
            c.lock_wait = (i == 4);
            c.lock_all = (i == 4) && ($urandom_range(1, 0) == 1);
            c.lock_mask = NUM_DLL'(1) << $urandom_range(NUM_DLL - 1, 0);
            RESTART_N = 1'b0;
            t = 0;
            while (CLEAR_STATUS_OE !== 1'b1 && t < RESTART_LAT_CYCLES) begin
                cyc(1);
                t++;
            end
            `CHK(CLEAR_STATUS_OE, 1'b1, "restart not answered")
            RESTART_N = 1'b1;
            run_seq(c, CLEAR_CYCLES - 12, CLEAR_CYCLES + 8);
        end
        // enable low freezes all state: neither a long restart nor the divider may move
        CE = 1'b0;
        cc = CONFIG_CLOCK;
        RESTART_N = 1'b0;
        cyc(12);
        `CHK(CONFIG_CLOCK, cc, "config clock moved with enable low")
        `CHK(CLEAR_STATUS_OE, 1'b0, "restart taken with enable low")
        RESTART_N = 1'b1;
        cyc(2);
        CE = 1'b1;
        MASTER_MODE = 1'b0;
        cyc(2);
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            `CHK(CONFIG_CLOCK, 1'b0, "config clock out of master mode")
        end
        report_and_stop();
    end
    initial begin
        cyc(20000);
        n_mismatch++;
        report_and_stop();
    end
endmodule : css_sequencer_tb
`undef CHK
`default_nettype wire
